// >>> src/dslc_pkg.sv
// Package with frame layout, register selects and reset values for the DAC serial load control.
package dslc_pkg;

	// ==========================================================================
	// Frame and channel sizes.
	// ==========================================================================
	localparam int          FRAME_BITS   = 24;
	localparam int          CHANNELS     = 4;
	localparam int          CODE_W       = 16;
	localparam int          PIN_COUNT    = 9;
	localparam logic [4:0]  FRAME_BITS_C = 5'h18;

	// ==========================================================================
	// Register selects carried in a frame.
	// ==========================================================================
	localparam logic [2:0]  REG_DATA     = 3'h0;
	localparam logic [2:0]  REG_PORT     = 3'h1;
	localparam logic [2:0]  REG_CTRL     = 3'h2;

	// ==========================================================================
	// Field positions inside the port and control words.
	// ==========================================================================
	localparam int          PORT_DIR_LSB = 0;
	localparam int          PORT_LVL_LSB = 2;
	localparam int          PORT_PIN_LSB = 4;
	localparam int          CTRL_DAISY   = 0;

	// ==========================================================================
	// Values after reset and fixed codes.
	// ==========================================================================
	localparam logic [15:0] DATA_RESET   = 16'h0000;
	localparam logic [15:0] CLEAR_CODE   = 16'h0000;
	localparam logic [15:0] ZERO_CODE    = 16'h8000;
	localparam logic [1:0]  PORT_RESET   = 2'h0;
	localparam logic        DAISY_RESET  = 1'b0;
	localparam logic [8:0]  PIN_RESET    = 9'h1ff;
	localparam logic [4:0]  COUNT_RESET  = 5'h00;

	// One 24-bit command frame, first bit shifted in is the read flag.
	typedef struct packed
	{
		logic        rd;
		logic [1:0]  pad;
		logic [2:0]  reg_sel;
		logic [1:0]  chan;
		logic [15:0] data;
	} dslc_frame_s;

	// Synchronised pin levels.
	typedef struct packed
	{
		logic        frame_n;
		logic        sclk;
		logic        sin;
		logic        clear_n;
		logic        load_n;
		logic        clamp_n;
		logic        coding;
		logic [1:0]  port;
	} dslc_pins_s;

endpackage

// >>> src/dslc_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module dslc_sync
#(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
)
(
	input  wire logic         core_clk_i,   // Core clock.
	input  wire logic         reset_i,      // Synchronous reset, active high.
	input  wire logic [W-1:0] async_i,      // Levels from outside the clock domain.
	output logic      [W-1:0] sync_o        // Levels after two flip-flops.
);
	logic [W-1:0] meta;

	// ==========================================================================
	// Two flops; the first is read by the second alone to contain metastability.
	// ==========================================================================
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			meta   <= RST_VAL;
			sync_o <= RST_VAL;
		end
		else
		begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule

// >>> src/dslc_top.sv
// Serial load control of a quad DAC: frame decode, data registers, load strobe, clear, clamp and port.
// Behaviour
// - Serial bits are taken only while the active-low frame select is low.
// - Each serial input bit is shifted in on a falling serial clock edge.
// - In daisy-chain or readback, shift register contents leave on serial output.
// - A falling clear edge loads zero into the data registers.
// - Load strobe low at frame end updates the addressed output directly.
// - Load strobe high updates only the input register; output waits for strobe.
// - A falling load strobe copies all input registers to outputs together.
// - Two port bits, each input or output, set and read by frames.
// - Clamp low forces all outputs to zero volts, registers untouched.
// - Coding select high means offset binary, low means twos complement.
`timescale 1ns/1ps
module dslc_top
(
	input  wire logic                    core_clk_i,     // Core clock, 200 MHz.
	input  wire logic                    reset_i,        // Synchronous reset, active high.
	input  wire logic                    frame_n_i,      // Frame select pin, active low.
	input  wire logic                    sclk_i,         // Serial clock pin.
	input  wire logic                    serial_in_i,    // Serial data pin.
	input  wire logic                    clear_edge_n_i, // Clear pin, falling edge acts.
	input  wire logic                    load_strobe_n_i, // Load strobe pin, active low.
	input  wire logic                    output_clamp_n_i, // Clamp pin, active low.
	input  wire logic                    coding_select_i, // High offset binary, low twos complement.
	input  wire logic [1:0]              port_bit_i,     // Port pin levels, bit 0 and bit 1.
	output logic      [1:0]              port_bit_o,     // Port pin drive levels.
	output logic      [1:0]              port_bit_oe_o,  // Port pin drive enables, high drives.
	output logic                         serial_out_o,   // Serial data output.
	output logic [3:0][15:0]             dac_code_o      // Offset-binary codes to the converters.
);
	import dslc_pkg::*;

	dslc_pins_s  pin_s;
	dslc_frame_s cmd;
	logic [FRAME_BITS-1:0] shreg;
	logic [4:0]            bit_cnt;
	logic                  frame_q;
	logic                  sclk_q;
	logic                  clear_q;
	logic                  load_q;
	logic                  rb_pend;
	logic                  daisy;
	logic [1:0]            port_dir;
	logic [1:0]            port_lvl;
	logic [15:0]           dac_in  [CHANNELS];
	logic [15:0]           dac_out [CHANNELS];
	logic [15:0]           next_rb_word;

	// ==========================================================================
	// Pin synchronisers and edge history.
	// ==========================================================================
	dslc_sync #(.W(PIN_COUNT), .RST_VAL(PIN_RESET)) u_sync
	(
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.async_i    ({frame_n_i, sclk_i, serial_in_i, clear_edge_n_i, load_strobe_n_i,
		              output_clamp_n_i, coding_select_i, port_bit_i}),
		.sync_o     (pin_s)
	);

	// Previous synchronised levels, used only for edge detection.
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			frame_q <= 1'b1;
			sclk_q  <= 1'b1;
			clear_q <= 1'b1;
			load_q  <= 1'b1;
		end
		else
		begin
			frame_q <= pin_s.frame_n;
			sclk_q  <= pin_s.sclk;
			clear_q <= pin_s.clear_n;
			load_q  <= pin_s.load_n;
		end
	end

	wire frame_active = ~pin_s.frame_n;
	wire frame_fall   = frame_q & ~pin_s.frame_n;
	wire frame_rise   = ~frame_q & pin_s.frame_n;
	wire sclk_fall    = sclk_q & ~pin_s.sclk;
	wire sclk_rise    = ~sclk_q & pin_s.sclk;
	wire clear_fall   = clear_q & ~pin_s.clear_n;
	wire load_fall    = load_q & ~pin_s.load_n;

	assign cmd = dslc_frame_s'(shreg);

	// Short frames are discarded; long daisy-chain frames use their last 24 bits.
	wire full_frame   = frame_rise & (bit_cnt == FRAME_BITS_C);
	wire commit       = full_frame & ~cmd.rd;
	wire data_commit  = commit & (cmd.reg_sel == REG_DATA);

	// Converts a stored code to the converter's offset-binary form.
	function automatic logic [15:0] to_offset(input logic [15:0] code, input logic offset_bin);
		to_offset = offset_bin ? code : {~code[15], code[14:0]};
	endfunction

	// ==========================================================================
	// Shift register and bit counter.
	// ==========================================================================
	// The counter saturates so a long chained frame still commits its last word.
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			shreg   <= '0;
			bit_cnt <= COUNT_RESET;
		end
		else if (frame_fall)
		begin
			bit_cnt <= COUNT_RESET;
		end
		else if (frame_active && sclk_fall)
		begin
			shreg   <= {shreg[FRAME_BITS-2:0], pin_s.sin};
			if (bit_cnt != FRAME_BITS_C)
				bit_cnt <= bit_cnt + 5'h01;
		end
		else if (full_frame && cmd.rd)
		begin
			shreg   <= {8'h00, next_rb_word};
		end
	end

	// Word returned by a read frame, shifted out during the following frame.
	always_comb
	begin
		case (cmd.reg_sel)
			REG_DATA: next_rb_word = dac_in[cmd.chan];
			REG_PORT: next_rb_word = {10'h000, pin_s.port, port_lvl, port_dir};
			REG_CTRL: next_rb_word = {15'h0000, daisy};
			default:  next_rb_word = 16'h0000;
		endcase
	end

	// Readback stays armed from the end of a read frame to the end of the next one.
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			rb_pend <= 1'b0;
		else if (frame_rise)
			rb_pend <= full_frame & cmd.rd;
	end

	// Output bit changes on rising clock edges so it is settled for the host's falling-edge sample.
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			serial_out_o <= 1'b0;
		else if (frame_active && sclk_rise)
			serial_out_o <= (daisy | rb_pend) & shreg[FRAME_BITS-1];
	end

	// ==========================================================================
	// Control and port registers.
	// ==========================================================================
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			daisy    <= DAISY_RESET;
			port_dir <= PORT_RESET;
			port_lvl <= PORT_RESET;
		end
		else if (commit && cmd.reg_sel == REG_PORT)
		begin
			port_dir <= cmd.data[PORT_DIR_LSB +: 2];
			port_lvl <= cmd.data[PORT_LVL_LSB +: 2];
		end
		else if (commit && cmd.reg_sel == REG_CTRL)
		begin
			daisy    <= cmd.data[CTRL_DAISY];
		end
	end

	// Port pins are driven only where configured as outputs.
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			port_bit_o    <= PORT_RESET;
			port_bit_oe_o <= PORT_RESET;
		end
		else
		begin
			port_bit_o    <= port_lvl;
			port_bit_oe_o <= port_dir;
		end
	end

	// ==========================================================================
	// Input and output data registers.
	// ==========================================================================
	// Clear overrides any frame or strobe in the same cycle.
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			for (int i = 0; i < CHANNELS; i++)
			begin
				dac_in[i]  <= DATA_RESET;
				dac_out[i] <= DATA_RESET;
			end
		end
		else if (clear_fall)
		begin
			for (int i = 0; i < CHANNELS; i++)
			begin
				dac_in[i]  <= CLEAR_CODE;
				dac_out[i] <= CLEAR_CODE;
			end
		end
		else
		begin
			if (load_fall)
			begin
				for (int i = 0; i < CHANNELS; i++)
					dac_out[i] <= dac_in[i];
			end
			if (data_commit)
			begin
				dac_in[cmd.chan] <= cmd.data;
				if (!pin_s.load_n)
					dac_out[cmd.chan] <= cmd.data;
			end
		end
	end

	// Clamp acts on the drive only, so stored codes survive it.
	generate
		for (genvar g = 0; g < CHANNELS; g++)
		begin : g_code
			always_ff @(posedge core_clk_i)
			begin
				if (reset_i)
					dac_code_o[g] <= ZERO_CODE;
				else if (!pin_s.clamp_n)
					dac_code_o[g] <= ZERO_CODE;
				else
					dac_code_o[g] <= to_offset(dac_out[g], pin_s.coding);
			end
		end
	endgenerate

	// ==========================================================================
	// Assertions.
	// ==========================================================================
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_clear_event;
		clear_fall;
	endsequence

	sequence s_direct_write;
		data_commit && !pin_s.load_n && !clear_fall;
	endsequence

	sequence s_deferred_write;
		data_commit && pin_s.load_n && !clear_fall;
	endsequence

	a_clear_zeroes: assert property (s_clear_event |=> dac_in[0] == CLEAR_CODE && dac_out[3] == CLEAR_CODE)
		else $error("clear edge did not zero the data registers");

	a_shift_capture: assert property (frame_active && sclk_fall && !frame_fall |=> shreg[0] == $past(pin_s.sin))
		else $error("serial bit not captured on falling clock");

	a_frame_only: assert property (!frame_active && sclk_fall |=> bit_cnt == $past(bit_cnt))
		else $error("bit counted outside a frame");

	a_idle_stable: assert property (pin_s.frame_n && frame_q |=> $stable(shreg) && $stable(bit_cnt))
		else $error("shift state changed while idle");

	a_direct_update: assert property (s_direct_write |=> dac_out[$past(cmd.chan)] == $past(cmd.data))
		else $error("output not updated with strobe low");

	// The write must leave the addressed output exactly as it was before the frame ended.
	a_deferred_hold: assert property (s_deferred_write |=>
		dac_out[$past(cmd.chan)] == $past(dac_out[cmd.chan]))
		else $error("output updated while strobe held high");

	a_strobe_all: assert property (load_fall && !clear_fall && !data_commit |=>
		{dac_out[0], dac_out[1], dac_out[2], dac_out[3]} == $past({dac_in[0], dac_in[1], dac_in[2], dac_in[3]}))
		else $error("strobe did not copy all channels");

	// Events one cycle back are the only legal reason for a stored output to move under clamp.
	a_clamp_zero: assert property (!pin_s.clamp_n ##1 !pin_s.clamp_n |->
		dac_code_o == {CHANNELS{ZERO_CODE}} &&
		({dac_out[0], dac_out[1], dac_out[2], dac_out[3]} == $past({dac_out[0], dac_out[1], dac_out[2], dac_out[3]}) ||
		$past(load_fall || clear_fall || data_commit)))
		else $error("clamp did not force zero code");

	a_coding_map: assert property (pin_s.clamp_n |=> dac_code_o[1] == to_offset($past(dac_out[1]), $past(pin_s.coding)))
		else $error("code conversion wrong for coding select");

	a_serial_drive: assert property (frame_active && sclk_rise && daisy |=> serial_out_o == $past(shreg[FRAME_BITS-1]))
		else $error("serial output does not follow shift register");

	a_port_enable: assert property (##1 port_dir == $past(port_dir) |=> port_bit_oe_o == $past(port_dir))
		else $error("port drive enable does not follow configuration");
endmodule

// >>> bench/dslc_host_model.sv
// Behavioural host serial controller driving frames into the DAC load control.
`timescale 1ns/1ps
module dslc_host_model
(
	output logic        frame_n_o,    // Frame select, active low.
	output logic        sclk_o,       // Serial clock, high outside frames except while idle_noise toggles it.
	output logic        serial_in_o,  // Serial data to the device.
	input  wire logic   serial_out_i, // Serial data from the device.
	output logic [47:0] rd_bits_o     // Bits seen on serial output, last seen lowest.
);
	// ==========================================================================
	// Idle levels.
	// ==========================================================================
	// The link starts idle with the clock parked high.
	initial
	begin
		frame_n_o   = 1'b1;
		sclk_o      = 1'b1;
		serial_in_o = 1'b0;
		rd_bits_o   = '0;
	end

	// ==========================================================================
	// Frame and noise tasks.
	// ==========================================================================
	// Sends the low nbits of word, MSB first, with a 48 ns clock period.
	// Pins change by non-blocking assignment, so a change that lands on a core clock edge never races it.
	task automatic send(input logic [47:0] word, input int nbits);
		frame_n_o <= 1'b0;
		#30;
		for (int i = 0; i < nbits; i++)
		begin
			serial_in_o <= word[nbits-1-i];            // Changes 24 ns away from the fall.
			#24;
			rd_bits_o = {rd_bits_o[46:0], serial_out_i};
			sclk_o <= 1'b0;
			#24;
			sclk_o <= 1'b1;
		end
		#30;
		frame_n_o <= 1'b1;                             // Ends the frame after the last fall.
		// A released data line shows the inverse so a stale bit never looks driven.
		serial_in_o <= ~serial_in_o;
		#100;
	endtask

	// Toggles clock and data with the frame closed, which the device must ignore.
	task automatic idle_noise(input int n);
		repeat (n)
		begin
			serial_in_o <= ~serial_in_o;
			#24 sclk_o <= 1'b0;
			#24 sclk_o <= 1'b1;
		end
	endtask
endmodule

// >>> bench/dac_serial_load_control_test.sv
// Self-checking testbench of the DAC serial load control with a host model on the link.
`timescale 1ns/1ps
module dac_serial_load_control_test;
	import dslc_pkg::*;
	logic             clk;
	logic             rst;
	logic             clr_n;
	logic             ld_n;
	logic             clamp_n;
	logic             coding;
	logic             frame_n;
	logic             sclk;
	logic             sin;
	logic             sout;
	logic [1:0]       pin_ext;
	logic [1:0]       port_in;
	logic [1:0]       port_o;
	logic [1:0]       port_oe;
	logic [3:0][15:0] code;
	logic [3:0][15:0] held;
	logic [47:0]      rd_bits;
	logic [15:0]      d;
	dslc_frame_s      f;
	dslc_frame_s      f0;
	int               n_mismatch;
	int               checks_done;

	// ==========================================================================
	// Clock, pins and instances.
	// ==========================================================================
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// A pin set as output shows the device's level, otherwise the external one.
	assign port_in = (port_oe & port_o) | (~port_oe & pin_ext);

	dslc_host_model host (.frame_n_o(frame_n), .sclk_o(sclk), .serial_in_o(sin), .serial_out_i(sout),
		.rd_bits_o(rd_bits));

	dslc_top dut (.core_clk_i(clk), .reset_i(rst), .frame_n_i(frame_n), .sclk_i(sclk), .serial_in_i(sin),
		.clear_edge_n_i(clr_n), .load_strobe_n_i(ld_n), .output_clamp_n_i(clamp_n),
		.coding_select_i(coding), .port_bit_i(port_in), .port_bit_o(port_o), .port_bit_oe_o(port_oe),
		.serial_out_o(sout), .dac_code_o(code));

	// ==========================================================================
	// Helpers.
	// ==========================================================================
	function automatic logic [15:0] conv(input logic [15:0] v, input logic c);
		return c ? v : {~v[15], v[14:0]};
	endfunction

	task automatic check(input logic [23:0] seen, input logic [23:0] want);
		checks_done++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic check_all();
		for (int i = 0; i < 4; i++)
			check({8'h00, code[i]}, {8'h00, conv(held[i], coding)});
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic setpins(input logic l, input logic cl, input logic cp, input logic cd);
		@(posedge clk);
		#1;
		ld_n = l;
		clr_n = cl;
		clamp_n = cp;
		coding = cd;
	endtask

	// One whole 24-bit frame, then time for the registers to follow.
	task automatic wr(input logic r, input logic [2:0] sel, input logic [1:0] ch, input logic [15:0] v);
		f = '{r, 2'b00, sel, ch, v};
		host.send({24'h000000, f}, 24);
		wait_cyc(8);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// A hang counts as a mismatch and closes the run.
	initial
	begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		test_done();
	end

	// ==========================================================================
	// Main sequence.
	// ==========================================================================
	initial
	begin
		{clr_n, ld_n, clamp_n, coding, rst} = 5'b10111;
		pin_ext = 2'b00;
		held = '0;
		n_mismatch = 0;
		checks_done = 0;
		void'($urandom(32'h3b343028));
		wait_cyc(10);
		rst = 1'b0;
		wait_cyc(5);
		// Direct writes with the strobe low, both codings, extreme code first.
		for (int i = 0; i < 8; i++)
		begin
			setpins(1'b0, 1'b1, 1'b1, 1'(i % 2));
			d = (i == 0) ? 16'hffff : 16'($urandom);
			wr(1'b0, REG_DATA, 2'(i), d);
			held[i % 4] = d;
			check_all();
		end
		// Strobe high defers, then one fall updates all channels at once.
		setpins(1'b1, 1'b1, 1'b1, 1'b1);
		for (int i = 0; i < 4; i++)
			wr(1'b0, REG_DATA, 2'(i), ~held[i]);
		check_all();
		held = ~held;
		setpins(1'b0, 1'b1, 1'b1, 1'b1);
		for (int k = 0; k < 20 && code[0] !== conv(held[0], coding); k++)
			wait_cyc(1);
		// A strobe that never lands uses up the bound and closes the run.
		if (code[0] !== conv(held[0], coding))
		begin
			n_mismatch++;
			test_done();
		end
		check_all();
		// Closed-frame noise and a short frame leave everything as it was.
		host.idle_noise(30);
		host.send({24'h000000, 24'h00ffff}, 23);
		wait_cyc(8);
		check_all();
		check(rd_bits[23:0], 24'h000000);
		// Clear edge in mid-frame, then a write still lands after it.
		fork
			wr(1'b0, REG_DATA, 2'd1, 16'h1234);
			begin
				#300;
				clr_n = 1'b0;
			end
		join
		held = '0;
		held[1] = 16'h1234;
		check_all();
		// Clamp forces zero volts and releases back to the stored codes.
		setpins(1'b0, 1'b1, 1'b0, 1'b0);
		wait_cyc(6);
		for (int i = 0; i < 4; i++)
			check({8'h00, code[i]}, {8'h00, ZERO_CODE});
		setpins(1'b0, 1'b1, 1'b1, 1'b0);
		wait_cyc(6);
		check_all();
		// Port bit 0 drives high, bit 1 reads the external low; read back both.
		wr(1'b0, REG_PORT, 2'd0, 16'h000d);
		check({22'h0, port_oe}, 24'h000001);
		check({22'h0, port_o}, 24'h000003);
		wr(1'b1, REG_PORT, 2'd0, 16'h0000);
		wr(1'b0, 3'h7, 2'd0, 16'h0000);
		check(rd_bits[23:0], 24'h00001d);
		wr(1'b1, REG_DATA, 2'd1, 16'h0000);
		wr(1'b0, 3'h7, 2'd0, 16'h0000);
		check(rd_bits[23:0], {8'h00, held[1]});
		// Daisy chain: a 48-bit frame passes its first word out and keeps the last.
		wr(1'b0, REG_CTRL, 2'd0, 16'h0001);
		d = 16'($urandom);
		f0 = 24'($urandom);
		f = '{1'b0, 2'b00, REG_DATA, 2'd3, d};
		host.send({f0, f}, 48);
		wait_cyc(8);
		held[3] = d;
		check(rd_bits[23:0], f0);
		check_all();
		// Mid-run reset returns every output to its idle value and zeroes the stored codes.
		rst = 1'b1;
		wait_cyc(4);
		for (int i = 0; i < 4; i++)
			check({8'h00, code[i]}, {8'h00, ZERO_CODE});
		check({19'h0, sout, port_o, port_oe}, 24'h000000);
		rst = 1'b0;
		wait_cyc(5);
		held = '0;
		check_all();
		test_done();
	end
endmodule
